// file: src/ssc_top.sv
`timescale 1ns/100ps
// Function
// - with full sleep enabled, use normal, light and deep sleep states
// - in normal with sleep enabled, enter light sleep after inactivity time
// - light sleep holds until motion or wake bit, then back to normal
// - with deep allowed, light sleep goes deep after longer inactivity time
// - deep sleep holds until motion or forced wake, then back to normal
// - inactivity times come from the programmable entry time register
// - each one-shot bit clears itself one cycle after it is written, whether or not it acted
// - sleep enable low means no sleep state is ever entered
// - sleep enabled with deep disallowed never enters deep sleep
module ssc_top
#(
    parameter int CYC_PER_MS = ssc_pkg::SSC_CYC_PER_MS
)
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address
    input  wire logic [3:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [3:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // sensor side
    input  wire logic                  motion_detect,
    output ssc_pkg::ssc_state_t        power_state,
    output logic                       adaptive_frame_rate,
    output logic                       led_shutter_allow
);
    import ssc_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [31:0] entry_r;
    logic [31:0] entry_nxt;
    ssc_state_t  state_r;
    ssc_state_t  state_nxt;
    logic [3:0]  aw_addr_r;
    logic        aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_held_r;
    logic [15:0] elapsed_ms;

    // apply byte enables to a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                res[8*i +: 8] = wd[8*i +: 8];
        return res;
    endfunction

    // address decode, shared by both channels
    function automatic logic mapped(input logic [3:0] a);
        return a == SSC_OFS_CTRL || a == SSC_OFS_ENTRY || a == SSC_OFS_STATUS;
    endfunction

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    wire         wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;
    wire         wr_ctrl   = wr_fire && aw_addr_r == SSC_OFS_CTRL;
    wire         wr_entry  = wr_fire && aw_addr_r == SSC_OFS_ENTRY;
    wire  [31:0] ctrl_wr   = merge({24'h0, ctrl_r}, w_data_r, w_strb_r);
    wire         aw_take   = s_axi_awvalid && s_axi_awready;
    wire         w_take    = s_axi_wvalid && s_axi_wready;

    // address and data are caught separately, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            aw_addr_r    <= 4'h0;
            w_data_r     <= 32'h0;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SSC_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
            if (w_take)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= (aw_held_r || aw_take) && !wr_fire;
            w_held_r  <= (w_held_r || w_take) && !wr_fire;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_r) ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ready while the matching holding slot is free
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !(aw_held_r || aw_take) || wr_fire;
            s_axi_wready  <= !(w_held_r || w_take) || wr_fire;
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    wire         ar_take   = s_axi_arvalid && s_axi_arready;
    wire  [3:0]  ar_word   = {s_axi_araddr[3:2], 2'b00};
    wire  [31:0] rd_mux    = ar_word == SSC_OFS_CTRL  ? {24'h0, ctrl_r} :
                             ar_word == SSC_OFS_ENTRY ? entry_r :
                             ar_word == SSC_OFS_STATUS ?
                                 {13'h0, adaptive_frame_rate, state_r, elapsed_ms} : 32'h0;

    // one read at a time, answered the cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= SSC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= mapped(ar_word) ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control and entry time registers
    // ----------------------------------------------------------------
    wire sleep_en   = ctrl_r[SSC_BIT_SLEEP];
    wire deep_allow = ctrl_r[SSC_BIT_DALLOW];
    wire f_wake     = ctrl_r[SSC_BIT_WAKE];
    wire f_light    = ctrl_r[SSC_BIT_FLIGHT];
    wire f_deep     = ctrl_r[SSC_BIT_FDEEP];

    // a fresh write beats the self clear of the one-shot bits
    assign ctrl_nxt  = wr_ctrl ? ((ctrl_wr[7:0] & ~SSC_CTRL_FMASK) | SSC_CTRL_FIXED)
                               : (ctrl_r & ~SSC_ONESHOT);
    assign entry_nxt = wr_entry ? merge(entry_r, w_data_r, w_strb_r) : entry_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r  <= SSC_CTRL_RST;
            entry_r <= {SSC_DEEP_MS, SSC_LIGHT_MS};
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            entry_r <= entry_nxt;
        end
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    wire [15:0] light_ms = entry_r[15:0];
    wire [15:0] deep_ms  = entry_r[31:16];
    wire        restart  = motion_detect || state_nxt != state_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SSC_NORMAL:
                if (!motion_detect && sleep_en)
                begin
                    if (f_deep && deep_allow)
                        state_nxt = SSC_DEEP;
                    else if (f_light || elapsed_ms >= light_ms)
                        state_nxt = SSC_LIGHT;
                end
            SSC_LIGHT:
                if (motion_detect || f_wake)
                    state_nxt = SSC_NORMAL;
                else if (sleep_en && deep_allow && (f_deep || elapsed_ms >= deep_ms))
                    state_nxt = SSC_DEEP;
            SSC_DEEP:
                if (motion_detect || f_wake)
                    state_nxt = SSC_NORMAL;
            default:
                state_nxt = SSC_NORMAL;
        endcase
    end

    // three states, all driven out directly
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r             <= SSC_NORMAL;
            power_state         <= SSC_NORMAL;
            adaptive_frame_rate <= 1'b0;
            led_shutter_allow   <= 1'b0;
        end
        else
        begin
            state_r             <= state_nxt;
            power_state         <= state_nxt;
            adaptive_frame_rate <= ctrl_nxt[SSC_BIT_SLEEP];
            led_shutter_allow   <= ctrl_nxt[SSC_BIT_LED];
        end
    end

    // inactivity timer, restarted by motion and every state change
    ssc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer
    (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .restart    (restart),
        .elapsed_ms (elapsed_ms)
    );
endmodule

// file: src/ssc_pkg.sv
package ssc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0]  SSC_OFS_CTRL    = 4'h0;   // power_state_control
    localparam logic [3:0]  SSC_OFS_ENTRY   = 4'h4;   // entry time setting
    localparam logic [3:0]  SSC_OFS_STATUS  = 4'h8;   // power state status
    // ----------------------------------------------------------------
    // power_state_control fields
    // ----------------------------------------------------------------
    localparam int          SSC_BIT_WAKE    = 0;
    localparam int          SSC_BIT_FLIGHT  = 1;      // force_light_sleep
    localparam int          SSC_BIT_FDEEP   = 2;      // force_deep_sleep
    localparam int          SSC_BIT_DALLOW  = 3;      // deep_sleep_allow
    localparam int          SSC_BIT_SLEEP   = 4;      // sleep enable
    localparam int          SSC_BIT_LED     = 7;      // led_shutter_allow
    localparam logic [7:0]  SSC_CTRL_RST    = 8'hB8;
    localparam logic [7:0]  SSC_CTRL_FIXED  = 8'h20;  // bits 6:5 read as 01
    localparam logic [7:0]  SSC_CTRL_FMASK  = 8'h60;
    localparam logic [7:0]  SSC_ONESHOT     = 8'h07;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          SSC_CLK_HZ      = 50_000_000;
    localparam int          SSC_MS_NS       = 1_000_000;
    localparam int          SSC_CLK_NS      = 1_000_000_000 / SSC_CLK_HZ;
    localparam int          SSC_CYC_PER_MS  = SSC_MS_NS / SSC_CLK_NS;
    localparam logic [15:0] SSC_LIGHT_MS    = 16'h0100;   // 256 ms
    localparam logic [15:0] SSC_DEEP_MS     = 16'h4E20;   // 20000 ms
    localparam logic [1:0]  SSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SSC_RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // power states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SSC_NORMAL, SSC_LIGHT, SSC_DEEP} ssc_state_t;
endpackage

// file: src/ssc_ms_timer.sv
`timescale 1ns/100ps
// counts whole milliseconds of inactivity, saturating
module ssc_ms_timer
#(
    parameter int CYC_PER_MS = ssc_pkg::SSC_CYC_PER_MS
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // control
    input  wire logic        restart,
    // elapsed time
    output logic      [15:0] elapsed_ms
);
    import ssc_pkg::*;

    logic [31:0] pre_r;
    logic        tick;

    assign tick = (pre_r == 32'(CYC_PER_MS - 1));

    // millisecond prescaler
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart || tick)
            pre_r <= 32'h0;
        else
            pre_r <= pre_r + 32'h1;
    end

    // millisecond counter, holds at full scale
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart)
            elapsed_ms <= 16'h0;
        else if (tick && elapsed_ms != 16'hFFFF)
            elapsed_ms <= elapsed_ms + 16'h1;
    end
endmodule

// file: test/ssc_checker.sv
`timescale 1ns/100ps
// ------
// power state and register bus checker
// ------
module ssc_checker
#(
    parameter int CYC_PER_MS = ssc_pkg::SSC_CYC_PER_MS
)
(
    // clock and reset
    input wire logic                aclk,
    input wire logic                aresetn,
    // register bus
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // sensor side
    input wire logic                motion_detect,
    input wire ssc_pkg::ssc_state_t power_state,
    input wire logic                adaptive_frame_rate
);
    import ssc_pkg::*;
    // one clock, reset disables all checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    motion_wake_a: assert property (motion_detect |=> power_state == SSC_NORMAL)
        else $error("motion did not return to normal");
    sleep_off_a: assert property (power_state == SSC_NORMAL && !adaptive_frame_rate ##1 !adaptive_frame_rate
        |-> power_state == SSC_NORMAL) else $error("sleep entered while disabled");
    deep_exit_a: assert property (power_state == SSC_DEEP |=> power_state != SSC_LIGHT)
        else $error("deep sleep went to light sleep");
    state_code_a: assert property (power_state inside {SSC_NORMAL, SSC_LIGHT, SSC_DEEP})
        else $error("illegal power state");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write response late");
    // main scenarios
    cover property (power_state == SSC_NORMAL ##1 power_state == SSC_LIGHT);
    cover property (power_state == SSC_LIGHT ##1 power_state == SSC_DEEP);
    cover property (power_state == SSC_DEEP ##1 power_state == SSC_NORMAL);
endmodule

// file: test/tb_ssc_top.sv
`timescale 1ns/100ps
// ------
// bench for the sleep mode controller
// ------
module tb_ssc_top;
    import ssc_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, motion_detect = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        adaptive_frame_rate, led_shutter_allow;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  v;
    ssc_state_t  power_state;
    int          fails = 0, tests_run = 0, n, seed = 32'h0C9CC032;
    localparam logic [7:0] codes [7] = '{8'hBA, 8'hB9, 8'hBC, 8'hB9, 8'hBA, 8'hBC, 8'hB9};
    localparam ssc_state_t dests [7] = '{SSC_LIGHT, SSC_NORMAL, SSC_DEEP, SSC_NORMAL, SSC_LIGHT, SSC_DEEP, SSC_NORMAL};
    // 50 MHz clock
    always #10 aclk = ~aclk;
    ssc_top #(.CYC_PER_MS(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .motion_detect, .power_state, .adaptive_frame_rate, .led_shutter_allow);
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // control read-back: one-shots cleared, bits 6:5 fixed
    function automatic logic [31:0] ctl_exp(input logic [7:0] c);
        return {24'h0, (c & ~(SSC_ONESHOT | SSC_CTRL_FMASK)) | SSC_CTRL_FIXED};
    endfunction
    // one bus write, both channels offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($random(seed));
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'b1;
        end
        while (!(s_axi_bready && s_axi_bvalid) && n < 50);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n >= 50) fails++;
    endtask
    // one bus read
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($random(seed));
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'b1;
        end
        while (!(s_axi_rready && s_axi_rvalid) && n < 50);
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 50) fails++;
    endtask
    // wait for a power state, n counts the cycles
    task automatic wait_st(input ssc_state_t s, input int lim);
        n = 0;
        while (power_state !== s && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic st_is(input ssc_state_t s, input string msg);
        check({30'h0, power_state}, {30'h0, s}, msg);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SSC_OFS_CTRL);
        check(rd_data, {24'h0, SSC_CTRL_RST}, "ctrl reset");
        rd(SSC_OFS_ENTRY);
        check(rd_data, {SSC_DEEP_MS, SSC_LIGHT_MS}, "entry reset");
        rd(4'hC);
        check({30'h0, resp}, {30'h0, SSC_RESP_SLVERR}, "unmapped read");
        check(rd_data, 32'h0, "unmapped read data");
        wr(4'hC, 32'hFFFFFFFF);
        check({30'h0, resp}, {30'h0, SSC_RESP_SLVERR}, "unmapped write");
        $display("reset test done");
        motion_detect <= 1'b0;
        foreach (codes[i])
        begin
            wr(SSC_OFS_CTRL, {24'h0, codes[i]});
            repeat (2) @(posedge aclk);
            st_is(dests[i], "forced state");
            rd(SSC_OFS_STATUS);
            check({29'h0, rd_data[18:16]}, {29'h0, 1'b1, dests[i]}, "status state");
            rd(SSC_OFS_CTRL);
            check(rd_data, ctl_exp(codes[i]), "one-shot clear");
        end
        $display("force test done");
        motion_detect <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            v = (r[7:0] & 8'h98) | SSC_CTRL_FIXED;
            wr(SSC_OFS_CTRL, {24'h0, v});
            rd(SSC_OFS_CTRL);
            check(rd_data, ctl_exp(v), "ctrl read-back");
            check({31'h0, adaptive_frame_rate}, {31'h0, v[SSC_BIT_SLEEP]}, "frame rate");
            check({31'h0, led_shutter_allow}, {31'h0, v[SSC_BIT_LED]}, "led shutter");
            wr(SSC_OFS_ENTRY, r);
            rd(SSC_OFS_ENTRY);
            check(rd_data, r, "entry read-back");
        end
        $display("register test done");
        s_axi_wstrb <= 4'hC;
        wr(SSC_OFS_ENTRY, 32'h0005FFFF);
        s_axi_wstrb <= 4'h3;
        wr(SSC_OFS_ENTRY, 32'hFFFF0003);
        s_axi_wstrb <= 4'hF;
        rd(SSC_OFS_ENTRY);
        check(rd_data, 32'h00050003, "byte lanes");
        wr(SSC_OFS_CTRL, 32'h000000B8);
        motion_detect <= 1'b0;
        wait_st(SSC_LIGHT, 200);
        check({31'h0, n >= 30 && n <= 45}, 32'h1, "light entry time");
        wait_st(SSC_DEEP, 200);
        check({31'h0, n >= 50 && n <= 65}, 32'h1, "deep entry time");
        motion_detect <= 1'b1;
        repeat (2) @(posedge aclk);
        st_is(SSC_NORMAL, "motion wakes deep");
        motion_detect <= 1'b0;
        wait_st(SSC_LIGHT, 200);
        motion_detect <= 1'b1;
        repeat (2) @(posedge aclk);
        st_is(SSC_NORMAL, "motion wakes light");
        $display("timing test done");
        wr(SSC_OFS_CTRL, 32'h000000B0);
        motion_detect <= 1'b0;
        wait_st(SSC_LIGHT, 200);
        wr(SSC_OFS_CTRL, 32'h000000B4);
        wait_st(SSC_DEEP, 150);
        st_is(SSC_LIGHT, "deep stays off");
        wr(SSC_OFS_CTRL, 32'h000000A0);
        wr(SSC_OFS_CTRL, 32'h000000A1);
        repeat (2) @(posedge aclk);
        check({31'h0, adaptive_frame_rate}, 32'h0, "frame rate off");
        wr(SSC_OFS_CTRL, 32'h000000A2);
        wait_st(SSC_LIGHT, 150);
        st_is(SSC_NORMAL, "held in normal");
        $display("disable test done");
        for (int i = 0; i < 30; i++)
        begin
            r = $random(seed);
            motion_detect <= r[8];
            repeat (r[5:0] + 1) @(posedge aclk);
        end
        $display("random motion test done");
        tally_and_finish();
    end
endmodule
bind ssc_top ssc_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .motion_detect, .power_state, .adaptive_frame_rate);
